// File: core/icea_pkg.sv
// Package for the instruction classifier and effective address generator.
// Assumes a 32-bit core; instruction words numbered with bit 31 as the msb.
package icea_pkg;

    localparam logic [31:0] ICEA_PROG_VECTOR   = 32'h0000_0700;
    localparam int          ICEA_PO_MSB        = 31;
    localparam int          ICEA_PO_LSB        = 26;
    localparam int          ICEA_XO_MSB        = 10;
    localparam int          ICEA_XO_LSB        = 1;
    localparam int          ICEA_XO19_MSB      = 10;
    localparam int          ICEA_XO19_LSB      = 1;
    localparam int          ICEA_XOA_MSB       = 5;
    localparam int          ICEA_XOA_LSB       = 1;
    localparam int          ICEA_RA_MSB        = 20;
    localparam int          ICEA_RA_LSB        = 16;

    typedef enum logic [1:0]
    {
        ICEA_CLS_DEFINED  = 2'h0,
        ICEA_CLS_ILLEGAL  = 2'h1,
        ICEA_CLS_RESERVED = 2'h2
    } icea_class_t;

    typedef enum logic [2:0]
    {
        ICEA_AM_REG_IMM  = 3'h0,
        ICEA_AM_REG_REG  = 3'h1,
        ICEA_AM_REG      = 3'h2,
        ICEA_AM_BR_IMM   = 3'h3,
        ICEA_AM_BR_LINK  = 3'h4,
        ICEA_AM_BR_COUNT = 3'h5,
        ICEA_AM_BR_ABS   = 3'h6
    } icea_amode_t;

    typedef struct packed
    {
        logic [31:0] word;
        logic [31:0] pc;
        logic        user_mode;
    } icea_fetch_t;

    typedef struct packed
    {
        logic        valid;
        icea_class_t cls;
        logic        illegal_trap;
        logic        writeback_en;
        logic [31:0] word;
        logic [31:0] pc;
        logic [31:0] vector;
    } icea_dec_t;

    typedef struct packed
    {
        icea_amode_t mode;
        logic [31:0] base;
        logic [31:0] index;
        logic [31:0] link;
        logic [31:0] count;
        logic [31:0] pc;
        logic [2:0]  len_log2;
        logic        little_endian;
    } icea_ea_req_t;

endpackage : icea_pkg

// File: core/icea_ea_gen.sv
// Effective address generator: combinational, 32-bit wraparound arithmetic.
// Assumes operands arrive already selected from the register file.
`timescale 1ns/1ps
module icea_ea_gen
(
    input  icea_pkg::icea_ea_req_t req,
    output logic [31:0]            effective_addr,
    output logic                   misaligned,
    output logic [31:0]            last_byte_addr,
    output logic                   wraps
);
    logic [32:0] sum;
    logic [32:0] end_sum;
    logic [31:0] len_mask;

    always_comb
    begin
        unique case (req.mode)
            icea_pkg::ICEA_AM_REG_IMM:  sum = {1'b0, req.base} + {1'b0, req.index};
            icea_pkg::ICEA_AM_REG_REG:  sum = {1'b0, req.base} + {1'b0, req.index};
            icea_pkg::ICEA_AM_REG:      sum = {1'b0, req.base};
            icea_pkg::ICEA_AM_BR_IMM:   sum = {1'b0, req.pc} + {1'b0, req.index};
            icea_pkg::ICEA_AM_BR_LINK:  sum = {1'b0, req.link & 32'hffff_fffc};
            icea_pkg::ICEA_AM_BR_COUNT: sum = {1'b0, req.count & 32'hffff_fffc};
            icea_pkg::ICEA_AM_BR_ABS:   sum = {1'b0, req.index};
            default:                    sum = {1'b0, req.base};
        endcase
    end

    // Carry out of the msb is dropped
    assign effective_addr = sum[31:0];
    // Address names the lowest byte; length from instruction
    assign len_mask       = (32'h0000_0001 << req.len_log2) - 32'h0000_0001;
    assign end_sum        = {1'b0, effective_addr} + {1'b0, len_mask};
    assign last_byte_addr = end_sum[31:0];
    assign wraps          = end_sum[32];
    // Aligned only at a multiple of the operand length
    assign misaligned     = |(effective_addr & len_mask);
endmodule : icea_ea_gen

// File: core/icea_top.sv
// Instruction class decoder and effective address stage, one cycle registered.
// Assumes fetch presents one word per cycle with valid; same clock domain.
`timescale 1ns/1ps
module icea_top
#(
    parameter bit FPU_PRESENT = 1'b1
)
(
    input  logic                   ref_clk,
    input  logic                   sys_rst,
    input  logic                   fetch_valid,
    input  icea_pkg::icea_fetch_t  fetch,
    input  icea_pkg::icea_ea_req_t ea_req,
    input  logic                   ea_req_valid,
    output icea_pkg::icea_dec_t    dec_out,
    output logic                   ea_valid,
    output logic [31:0]            effective_addr,
    output logic [31:0]            ea_last_byte,
    output logic                   ea_misaligned,
    output logic                   ea_wraps,
    output logic                   ea_little_endian,
    output logic                   priv_user_mode
);

    icea_pkg::icea_dec_t dec_q;
    icea_pkg::icea_dec_t dec_d;
    logic                ea_valid_q;
    logic [31:0]         ea_q;
    logic [31:0]         ea_last_q;
    logic                ea_mis_q;
    logic                ea_wrap_q;
    logic                ea_le_q;
    logic                user_q;
    logic [31:0]         ea_comb;
    logic [31:0]         last_comb;
    logic                mis_comb;
    logic                wrap_comb;

    // X-form extended opcodes under primary 31 used by 32-bit cores
    function automatic logic ext31_ok(input logic [9:0] xo);
        logic [8:0] xo9;
        xo9 = xo[8:0];
        // Arithmetic XO-form: OE bit folded off
        unique case (xo9)
            9'd8, 9'd10, 9'd11, 9'd40, 9'd75, 9'd104, 9'd136, 9'd138,
            9'd200, 9'd202, 9'd232, 9'd234, 9'd235, 9'd266, 9'd459, 9'd491:
                return 1'b1;
            default: ;
        endcase
        // Remaining X-form extended opcodes, one to a line
        unique case (xo)
            10'd0,
            10'd4,
            10'd19,
            10'd20,
            10'd23,
            10'd24,
            10'd26,
            10'd28,
            10'd32,
            10'd54,
            10'd55,
            10'd60,
            10'd83,
            10'd86,
            10'd87,
            10'd119,
            10'd124,
            10'd144,
            10'd146,
            10'd150,
            10'd151,
            10'd183,
            10'd210,
            10'd215,
            10'd242,
            10'd246,
            10'd247,
            10'd278,
            10'd279,
            10'd284,
            10'd306,
            10'd310,
            10'd311,
            10'd316,
            10'd339,
            10'd343,
            10'd370,
            10'd371,
            10'd375,
            10'd407,
            10'd412,
            10'd438,
            10'd439,
            10'd444,
            10'd467,
            10'd470,
            10'd476,
            10'd512,
            10'd533,
            10'd534,
            10'd535,
            10'd536,
            10'd566,
            10'd567,
            10'd595,
            10'd597,
            10'd598,
            10'd599,
            10'd631,
            10'd659,
            10'd661,
            10'd662,
            10'd663,
            10'd695,
            10'd725,
            10'd727,
            10'd759,
            10'd790,
            10'd792,
            10'd824,
            10'd854,
            10'd918,
            10'd922,
            10'd954,
            10'd978,
            10'd982,
            10'd983,
            10'd1010,
            10'd1014:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : ext31_ok

    function automatic logic ext19_ok(input logic [9:0] xo);
        unique case (xo)
            10'd0, 10'd16, 10'd33, 10'd50, 10'd129, 10'd150, 10'd193,
            10'd225, 10'd257, 10'd289, 10'd417, 10'd449, 10'd528:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : ext19_ok

    // Square roots (22, 26 for 59) are omitted and fall through as illegal
    function automatic logic ext59_ok(input logic [4:0] xa);
        unique case (xa)
            5'd18, 5'd20, 5'd21, 5'd24, 5'd25, 5'd28, 5'd29, 5'd30, 5'd31:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : ext59_ok

    function automatic logic ext63_ok(input logic [9:0] xo);
        unique case (xo[4:0])
            5'd18, 5'd20, 5'd21, 5'd23, 5'd25, 5'd26, 5'd28, 5'd29, 5'd30,
            5'd31:
                return 1'b1;
            default: ;
        endcase
        unique case (xo)
            10'd0, 10'd12, 10'd14, 10'd15, 10'd32, 10'd38, 10'd40, 10'd64,
            10'd70, 10'd72, 10'd134, 10'd136, 10'd264, 10'd583, 10'd711:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : ext63_ok

    // Fixed-field primaries that 32-bit implementations define
    function automatic logic prim_ok(input logic [5:0] po);
        unique case (po)
            6'd3, 6'd7, 6'd8, 6'd10, 6'd11, 6'd12, 6'd13, 6'd14, 6'd15,
            6'd16, 6'd18, 6'd20, 6'd21, 6'd23, 6'd24, 6'd25, 6'd26, 6'd27,
            6'd28, 6'd29, 6'd32, 6'd33, 6'd34, 6'd35, 6'd36, 6'd37, 6'd38,
            6'd39, 6'd40, 6'd41, 6'd42, 6'd43, 6'd44, 6'd45, 6'd46, 6'd47,
            6'd48, 6'd49, 6'd50, 6'd51, 6'd52, 6'd53, 6'd54, 6'd55:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : prim_ok

    function automatic logic fp_prim(input logic [5:0] po);
        return (po >= 6'd48 && po <= 6'd55) || po == 6'd59 || po == 6'd63;
    endfunction : fp_prim

    // Floating loads and stores under primary 31
    function automatic logic fp_ext31(input logic [9:0] xo);
        unique case (xo)
            10'd535,
            10'd567,
            10'd599,
            10'd631,
            10'd663,
            10'd695,
            10'd727,
            10'd759,
            10'd983:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : fp_ext31

    logic [5:0] po;
    logic [9:0] xo;
    logic [4:0] xa;
    logic       known;

    assign po = fetch.word[icea_pkg::ICEA_PO_MSB:icea_pkg::ICEA_PO_LSB];
    assign xo = fetch.word[icea_pkg::ICEA_XO_MSB:icea_pkg::ICEA_XO_LSB];
    assign xa = fetch.word[icea_pkg::ICEA_XOA_MSB:icea_pkg::ICEA_XOA_LSB];

    always_comb
    begin
        known = 1'b0;
        unique case (po)
            6'd17:   known = fetch.word[1];
            6'd19:   known = ext19_ok(xo);
            6'd31:   known = ext31_ok(xo)
                             && (FPU_PRESENT || !fp_ext31(xo));
            6'd59:   known = ext59_ok(xa) && FPU_PRESENT;
            6'd63:   known = ext63_ok(xo) && FPU_PRESENT;
            6'd30,
            6'd62:   known = 1'b0;
            default: known = prim_ok(po) && (FPU_PRESENT || !fp_prim(po));
        endcase
    end

    always_comb
    begin
        dec_d       = '0;
        dec_d.valid = fetch_valid;
        dec_d.word  = fetch.word;
        dec_d.pc    = fetch.pc;
        if (fetch.word == 32'h0000_0000)
        begin
            dec_d.cls = icea_pkg::ICEA_CLS_ILLEGAL;
        end
        else if (po == 6'h00)
        begin
            dec_d.cls = icea_pkg::ICEA_CLS_RESERVED;
        end
        else if (known)
        begin
            dec_d.cls = icea_pkg::ICEA_CLS_DEFINED;
        end
        else
        begin
            dec_d.cls = icea_pkg::ICEA_CLS_ILLEGAL;
        end
        // Reserved words are not implemented here, so all of them trap
        dec_d.illegal_trap = fetch_valid && (dec_d.cls != icea_pkg::ICEA_CLS_DEFINED);
        dec_d.vector       = dec_d.illegal_trap ? icea_pkg::ICEA_PROG_VECTOR : 32'h0000_0000;
        dec_d.writeback_en = fetch_valid && !dec_d.illegal_trap;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            dec_q <= '0;
        end
        else
        begin
            dec_q <= dec_d;
        end
    end

    // Privilege level only follows fetch; no decoded word can raise it
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            user_q <= 1'b0;
        end
        else if (fetch_valid)
        begin
            user_q <= fetch.user_mode;
        end
    end

    icea_ea_gen u_ea
    (
        .req            (ea_req),
        .effective_addr (ea_comb),
        .misaligned     (mis_comb),
        .last_byte_addr (last_comb),
        .wraps          (wrap_comb)
    );

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ea_valid_q <= 1'b0;
            ea_q       <= 32'h0000_0000;
            ea_last_q  <= 32'h0000_0000;
            ea_mis_q   <= 1'b0;
            ea_wrap_q  <= 1'b0;
            ea_le_q    <= 1'b0;
        end
        else
        begin
            ea_valid_q <= ea_req_valid;
            ea_q       <= ea_comb;
            ea_last_q  <= last_comb;
            ea_mis_q   <= mis_comb;
            ea_wrap_q  <= wrap_comb;
            ea_le_q    <= ea_req.little_endian;
        end
    end

    assign dec_out          = dec_q;
    assign ea_valid         = ea_valid_q;
    assign effective_addr   = ea_q;
    assign ea_last_byte     = ea_last_q;
    assign ea_misaligned    = ea_mis_q;
    assign ea_wraps         = ea_wrap_q;
    assign ea_little_endian = ea_le_q;
    assign priv_user_mode   = user_q;

endmodule : icea_top

// File: tb/icea_top_checker.sv
// Checker for the classifier and address stage, bound to the top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module icea_top_checker
(
    input logic                   ref_clk,
    input logic                   sys_rst,
    input logic                   fetch_valid,
    input icea_pkg::icea_fetch_t  fetch,
    input icea_pkg::icea_ea_req_t ea_req,
    input logic                   ea_req_valid,
    input icea_pkg::icea_dec_t    dec_out,
    input logic                   ea_valid,
    input logic [31:0]            effective_addr,
    input logic [31:0]            ea_last_byte,
    input logic                   ea_misaligned,
    input logic                   ea_wraps,
    input logic                   ea_little_endian,
    input logic                   priv_user_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_trap_out;
        dec_out.valid && dec_out.illegal_trap;
    endsequence
    sequence s_ea_done;
        ea_req_valid ##1 ea_valid;
    endsequence
    chk_zero_word: assert property (fetch_valid && fetch.word == 32'h0
        |=> s_trap_out ##0 dec_out.cls == icea_pkg::ICEA_CLS_ILLEGAL) else $error("zero word");
    chk_prim_wide: assert property (fetch_valid && fetch.word[31:26] inside {6'h1e, 6'h3e}
        |=> s_trap_out ##0 dec_out.cls == icea_pkg::ICEA_CLS_ILLEGAL) else $error("wide opcode");
    chk_reserved_cls: assert property (fetch_valid && fetch.word[31:26] == 6'h0
        && fetch.word[25:0] != 26'h0 |=> s_trap_out ##0
        dec_out.cls == icea_pkg::ICEA_CLS_RESERVED) else $error("reserved class");
    chk_trap_vector: assert property (dec_out.illegal_trap |->
        dec_out.vector == icea_pkg::ICEA_PROG_VECTOR && !dec_out.writeback_en) else $error("trap");
    chk_word_passed: assert property (fetch_valid |=>
        dec_out.valid && dec_out.word == $past(fetch.word)) else $error("word lost");
    chk_user_held: assert property (fetch_valid && fetch.user_mode |=> priv_user_mode)
        else $error("privilege raised");
    chk_ea_wrap: assert property (ea_req_valid && ea_req.mode == icea_pkg::ICEA_AM_REG_IMM
        |=> effective_addr == $past(ea_req.base) + $past(ea_req.index)) else $error("ea sum");
    chk_link_target: assert property (ea_req_valid && ea_req.mode == icea_pkg::ICEA_AM_BR_LINK
        |=> effective_addr == ($past(ea_req.link) & ~32'h3)) else $error("link target");
    chk_ea_align: assert property (s_ea_done |-> ea_misaligned ==
        ((effective_addr & ((32'h1 << $past(ea_req.len_log2)) - 32'h1)) != 32'h0))
        else $error("alignment");
    chk_last_byte: assert property (s_ea_done |->
        ea_last_byte == effective_addr + (32'h1 << $past(ea_req.len_log2)) - 32'h1
        && ea_wraps == (ea_last_byte < effective_addr)) else $error("last byte");
    chk_byte_order: assert property (ea_req_valid |=>
        ea_little_endian == $past(ea_req.little_endian)) else $error("byte order");
endmodule : icea_top_checker

bind icea_top icea_top_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .fetch_valid(fetch_valid), .fetch(fetch), .ea_req(ea_req), .ea_req_valid(ea_req_valid),
    .dec_out(dec_out), .ea_valid(ea_valid), .effective_addr(effective_addr),
    .ea_last_byte(ea_last_byte), .ea_misaligned(ea_misaligned), .ea_wraps(ea_wraps),
    .ea_little_endian(ea_little_endian), .priv_user_mode(priv_user_mode));

// File: tb/icea_fetch_model.sv
// Fetch and load/store side model: presents words and address requests.
// Assumes the bench calls its tasks; all changes land on falling edges.
`timescale 1ns/1ps
module icea_fetch_model
(
    input  logic                   ref_clk,
    output logic                   fetch_valid,
    output icea_pkg::icea_fetch_t  fetch,
    output logic                   ea_req_valid,
    output icea_pkg::icea_ea_req_t ea_req
);
    initial
    begin
        fetch_valid  = 1'b0;
        fetch        = '0;
        ea_req_valid = 1'b0;
        ea_req       = '0;
    end
    task automatic send(input logic [31:0] w, input logic u);
        @(negedge ref_clk);
        fetch_valid = 1'b1;
        fetch       = '{word: w, pc: w ^ 32'h0000_1000, user_mode: u};
        @(posedge ref_clk);
    endtask : send
    task automatic addr(input icea_pkg::icea_ea_req_t r);
        @(negedge ref_clk);
        ea_req_valid = 1'b1;
        ea_req       = r;
        @(posedge ref_clk);
    endtask : addr
    // Released lines show the inverse of the last value
    task automatic idle();
        @(negedge ref_clk);
        fetch_valid  = 1'b0;
        fetch        = ~fetch;
        ea_req_valid = 1'b0;
        ea_req       = ~ea_req;
    endtask : idle
endmodule : icea_fetch_model

// File: tb/icea_top_tb.sv
// Self-checking bench for the classifier and address stage.
// Assumes the fetch model drives all request inputs on falling edges.
`timescale 1ns/1ps
module icea_top_tb;
    logic ref_clk, sys_rst, fetch_valid, ea_req_valid, ea_valid;
    logic ea_misaligned, ea_wraps, ea_little_endian, priv_user_mode;
    logic [31:0] effective_addr, ea_last_byte;
    icea_pkg::icea_fetch_t  fetch;
    icea_pkg::icea_ea_req_t ea_req;
    icea_pkg::icea_dec_t    dec_out;
    int failures;
    int checked;

    icea_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
        .fetch(fetch), .ea_req(ea_req), .ea_req_valid(ea_req_valid), .dec_out(dec_out),
        .ea_valid(ea_valid), .effective_addr(effective_addr), .ea_last_byte(ea_last_byte),
        .ea_misaligned(ea_misaligned), .ea_wraps(ea_wraps),
        .ea_little_endian(ea_little_endian), .priv_user_mode(priv_user_mode));
    icea_fetch_model fm (.ref_clk(ref_clk), .fetch_valid(fetch_valid), .fetch(fetch),
        .ea_req_valid(ea_req_valid), .ea_req(ea_req));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One word in user state; class, trap, vector, writeback and state out
    task automatic decode(input logic [31:0] w, input icea_pkg::icea_class_t c);
        logic t;
        t = (c != icea_pkg::ICEA_CLS_DEFINED);
        fm.send(w, 1'b1);
        #1;
        check(32'({dec_out.valid, dec_out.cls, dec_out.illegal_trap, dec_out.writeback_en,
            priv_user_mode}), 32'({1'b1, c, t, ~t, 1'b1}));
        check(dec_out.vector, t ? icea_pkg::ICEA_PROG_VECTOR : 32'h0);
        check(dec_out.word, w);
        check(dec_out.pc, w ^ 32'h0000_1000);
    endtask : decode
    task automatic t_zero_then_defined();
        decode(32'h0000_0000, icea_pkg::ICEA_CLS_ILLEGAL);
        decode(32'h3860_0001, icea_pkg::ICEA_CLS_DEFINED);
        decode(32'hc000_0000, icea_pkg::ICEA_CLS_DEFINED);
        decode(32'h7c00_0430, icea_pkg::ICEA_CLS_DEFINED);
        decode(32'h7c00_07ec, icea_pkg::ICEA_CLS_DEFINED);
        decode(32'h7c00_042e, icea_pkg::ICEA_CLS_DEFINED);
        decode(32'h00ff_0000, icea_pkg::ICEA_CLS_RESERVED);
        fm.idle();
    endtask : t_zero_then_defined
    task automatic t_illegal_codes();
        decode(32'h7800_0000, icea_pkg::ICEA_CLS_ILLEGAL);
        decode(32'hf800_0000, icea_pkg::ICEA_CLS_ILLEGAL);
        decode(32'h4c00_0002, icea_pkg::ICEA_CLS_ILLEGAL);
        decode(32'h7c00_0004, icea_pkg::ICEA_CLS_ILLEGAL);
        decode(32'h4c00_0024, icea_pkg::ICEA_CLS_ILLEGAL);
        decode(32'h7c00_0074, icea_pkg::ICEA_CLS_ILLEGAL);
        decode(32'hfc00_002c, icea_pkg::ICEA_CLS_ILLEGAL);
        decode(32'hec00_002c, icea_pkg::ICEA_CLS_ILLEGAL);
        fm.idle();
    endtask : t_illegal_codes
    // One address request; length, alignment and wrap worked out here
    task automatic ea(input icea_pkg::icea_amode_t m, input logic [31:0] b, x,
        input logic [2:0] l, input logic le, input logic [31:0] e);
        logic [31:0] last;
        last = e + (32'h1 << l) - 32'h1;
        fm.addr('{mode: m, base: b, index: x, link: 32'h2003, count: 32'h3007,
            pc: 32'h4000, len_log2: l, little_endian: le});
        #1;
        check(effective_addr, e);
        check(ea_last_byte, last);
        check(32'({ea_valid, ea_misaligned, ea_wraps, ea_little_endian}),
            32'({1'b1, (e & ((32'h1 << l) - 32'h1)) != 32'h0, last < e, le}));
    endtask : ea
    task automatic t_addr_modes();
        ea(icea_pkg::ICEA_AM_REG_IMM, 32'hffff_fffc, 32'h8, 3'h2, 1'b0, 32'h4);
        ea(icea_pkg::ICEA_AM_REG_REG, 32'h1000, 32'h2, 3'h2, 1'b1, 32'h1002);
        ea(icea_pkg::ICEA_AM_REG, 32'hffff_fffe, 32'h5, 3'h2, 1'b0, 32'hffff_fffe);
        ea(icea_pkg::ICEA_AM_REG_IMM, 32'h1003, 32'h0, 3'h0, 1'b0, 32'h1003);
        ea(icea_pkg::ICEA_AM_BR_IMM, 32'h0, 32'hffff_fff0, 3'h2, 1'b0, 32'h3ff0);
        ea(icea_pkg::ICEA_AM_BR_LINK, 32'h0, 32'h0, 3'h2, 1'b0, 32'h2000);
        ea(icea_pkg::ICEA_AM_BR_COUNT, 32'h0, 32'h0, 3'h2, 1'b0, 32'h3004);
        ea(icea_pkg::ICEA_AM_BR_ABS, 32'h0, 32'h0000_0100, 3'h2, 1'b0, 32'h100);
        fm.idle();
    endtask : t_addr_modes
    initial
    begin
        failures = 0;
        checked  = 0;
        sys_rst  = 1'b1;
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        check(32'({dec_out.valid, dec_out.illegal_trap, ea_valid}), 32'h0);
        t_zero_then_defined();
        t_illegal_codes();
        t_addr_modes();
        report_and_stop();
    end
    initial
    begin
        #100000;
        failures++;
        report_and_stop();
    end
endmodule : icea_top_tb
